// *** core/prx_regs.svh ***
// register offsets, field positions, symbol codes and indication codes
// assumes an includer that needs plain constants only
`ifndef PRX_REGS_SVH
`define PRX_REGS_SVH

`define PRX_ADR_CTRL      8'h00
`define PRX_ADR_STATUS    8'h04
`define PRX_ADR_JABCNT    8'h08
`define PRX_CTRL_LOOP_BIT 0
`define PRX_CTRL_RESET    32'h0000_0000
`define PRX_JAB_WIDTH     16

`define PRX_SYM_IDLE      5'h1f
`define PRX_SYM_SYNC      5'h18
`define PRX_SYM_SSD       5'h11
`define PRX_SYM_ESD       5'h0d
`define PRX_SYM_ESDOK     5'h07
`define PRX_SYM_ESDERR    5'h04
`define PRX_SYM_ESDJAB    5'h19
`define PRX_SYM_BEACON    5'h08

`define PRX_NIB_PREAMBLE  4'h5
`define PRX_NIB_BEACON    4'h2
`define PRX_NIB_COMMIT    4'h3
`define PRX_LOCK_SYMBOLS  4'h9
`define PRX_SCR_RESET     17'h0_0000

`endif

// *** core/prx_pkg.sv ***
// types shared by the receive coding logic
// assumes prx_regs.svh for the numeric constants
package prx_pkg;
	typedef enum logic [2:0] {
		PRX_ST_WAIT = 3'b000,
		PRX_ST_SSD  = 3'b001,
		PRX_ST_LOCK = 3'b010,
		PRX_ST_DATA = 3'b011,
		PRX_ST_END  = 3'b100
	} prx_state_t;
endpackage : prx_pkg

// *** core/prx_decode.sv ***
// reverse 4b/5b lookup of one received symbol
// assumes a symbol stable while it is read; purely combinational
`timescale 1ns/1ps
module prx_decode (
	input  wire logic [4:0] sym_i,
	output logic      [3:0] raw_nibble_o,
	output logic            valid_o
);
	always_comb begin
		valid_o      = 1'b1;
		raw_nibble_o = 4'h0;
		case (sym_i)
			5'h1e: raw_nibble_o = 4'h0;
			5'h09: raw_nibble_o = 4'h1;
			5'h14: raw_nibble_o = 4'h2;
			5'h15: raw_nibble_o = 4'h3;
			5'h0a: raw_nibble_o = 4'h4;
			5'h0b: raw_nibble_o = 4'h5;
			5'h0e: raw_nibble_o = 4'h6;
			5'h0f: raw_nibble_o = 4'h7;
			5'h12: raw_nibble_o = 4'h8;
			5'h13: raw_nibble_o = 4'h9;
			5'h16: raw_nibble_o = 4'ha;
			5'h17: raw_nibble_o = 4'hb;
			5'h1a: raw_nibble_o = 4'hc;
			5'h1b: raw_nibble_o = 4'hd;
			5'h1c: raw_nibble_o = 4'he;
			5'h1d: raw_nibble_o = 4'hf;
			// unmapped code: nibble left arbitrary (zero)
			default: valid_o = 1'b0;
		endcase
	end
endmodule : prx_decode

// *** core/prx_descrambler.sv ***
// self-synchronizing descrambler, one nibble per step
// assumes step_i is a one-cycle pulse on clk_i
`timescale 1ns/1ps
`include "prx_regs.svh"
module prx_descrambler (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       step_i,
	input  wire logic [3:0] raw_nibble_i,
	output logic      [3:0] clear_nibble_o
);
	logic [16:0] state;

	function automatic logic [20:0] descr(input logic [16:0] s, input logic [3:0] d);
		logic [16:0] t;
		logic [3:0]  c;
		t = s;
		c = 4'h0;
		for (int i = 0; i < 4; i++) begin
			c[i] = d[i] ^ t[13] ^ t[16];
			t    = {t[15:0], d[i]};
		end
		return {t, c};
	endfunction : descr

	logic [20:0] next_all;
	assign next_all       = descr(state, raw_nibble_i);
	assign clear_nibble_o = next_all[3:0];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= `PRX_SCR_RESET;
		end else if (step_i) begin
			state <= next_all[20:4];
		end
	end
endmodule : prx_descrambler

// *** core/prx_rx_decode.sv ***
// receive decode, descramble, loopback, crs/col for a 10 Mb/s multidrop phy
// assumes pma symbol, link clock, carrier and corruption inputs are asynchronous
// to clk_i; mac transmit inputs are on clk_i; wishbone classic slave on clk_i
// Operation
// - decode symbol, then descramble the nibble
// - unmapped symbol in data raises receive error
// - descrambler shares transmit polynomial, 17 bits
// - nibble bits enter lsb first
// - pcs reset resets descrambler state
// - idle ticks may feed arbitrary bits
// - symbol tick fires per received symbol
// - count jabber end delimiters for software
// - loopback bit enables pcs loopback
// - loopback returns transmit nibbles on receive
// - loopback isolates medium, blocks transmission
// - col while corruption lasts and transmitting
// - col when others transmit with us
// - crs on collision of other stations
// - crs follows medium carrier indication
// - constant states false carrier support
// - symbol n is the beacon
// - two beacons give beacon indication
// - two syncs give commit indication
// - skip nine symbols after second ssd
// - send nibble five while locking
`timescale 1ns/1ps
`include "prx_regs.svh"
module prx_rx_decode
	import prx_pkg::*;
#(
	parameter bit FALSE_CARRIER_OPTION = 1'b0
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        pma_rxclk_i,
	input  wire logic [4:0]  pma_sym_i,
	input  wire logic        pma_crs_i,
	input  wire logic        pma_corrupt_i,
	input  wire logic        tx_en_i,
	input  wire logic        tx_er_i,
	input  wire logic [3:0]  txd_i,
	output logic             pma_tx_en_o,
	output logic             pma_tx_er_o,
	output logic      [3:0]  pma_txd_o,
	output logic      [3:0]  rxd_o,
	output logic             rx_dv_o,
	output logic             rx_er_o,
	output logic             crs_o,
	output logic             col_o
);
	logic [7:0]  sync1;
	logic [7:0]  sync2;
	logic        clk_s3;
	logic        tick;
	logic [4:0]  sym;
	logic        crs_s;
	logic        corrupt_s;
	logic        loopback;
	logic [`PRX_JAB_WIDTH-1:0] jab_count;
	prx_state_t  state;
	logic [3:0]  lock_cnt;
	logic        beacon_seen;
	logic        sync_seen;
	logic [3:0]  raw_nibble;
	logic        raw_valid;
	logic [3:0]  clear_nibble;
	logic        jab_event;
	logic        wb_req;
	logic        jab_clear;

	// two-flop synchronisers; the second stage is read, and a third flop on the link clock is read for edge detect
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1  <= 8'h00;
			sync2  <= 8'h00;
			clk_s3 <= 1'b0;
		end else begin
			sync1  <= {pma_rxclk_i, pma_crs_i, pma_corrupt_i, pma_sym_i};
			sync2  <= sync1;
			clk_s3 <= sync2[7];
		end
	end
	assign crs_s     = sync2[6];
	assign corrupt_s = sync2[5];
	assign sym       = sync2[4:0];
	assign tick      = sync2[7] & ~clk_s3;

	prx_decode u_decode (
		.sym_i        (sym),
		.raw_nibble_o (raw_nibble),
		.valid_o      (raw_valid)
	);

	// clocked every tick, invalid codes feed zero
	prx_descrambler u_descr (
		.clk_i          (clk_i),
		.rst_i          (rst_i),
		.step_i         (tick),
		.raw_nibble_i   (raw_nibble),
		.clear_nibble_o (clear_nibble)
	);

	// receive sequencing
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state       <= PRX_ST_WAIT;
			lock_cnt    <= 4'h0;
			beacon_seen <= 1'b0;
			sync_seen   <= 1'b0;
		end else if (tick) begin
			case (state)
				PRX_ST_WAIT: begin
					beacon_seen <= (sym == `PRX_SYM_BEACON);
					sync_seen   <= (sym == `PRX_SYM_SYNC);
					if (sym == `PRX_SYM_SSD && sync_seen) begin
						state <= PRX_ST_SSD;
					end
				end
				PRX_ST_SSD: begin
					lock_cnt <= 4'h0;
					state    <= (sym == `PRX_SYM_SSD) ? PRX_ST_LOCK : PRX_ST_WAIT;
				end
				PRX_ST_LOCK: begin
					lock_cnt <= lock_cnt + 4'h1;
					if (lock_cnt == `PRX_LOCK_SYMBOLS - 4'h1) begin
						state <= PRX_ST_DATA;
					end
				end
				PRX_ST_DATA: begin
					if (sym == `PRX_SYM_ESD) begin
						state <= PRX_ST_END;
					end else if (sym == `PRX_SYM_IDLE) begin
						state <= PRX_ST_WAIT;
					end
				end
				default: begin
					beacon_seen <= 1'b0;
					sync_seen   <= 1'b0;
					state       <= PRX_ST_WAIT;
				end
			endcase
		end
	end

	// receive outputs; in loopback the transmit path is returned each cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rxd_o   <= 4'h0;
			rx_dv_o <= 1'b0;
			rx_er_o <= 1'b0;
		end else if (loopback) begin
			rxd_o   <= txd_i;
			rx_dv_o <= tx_en_i;
			rx_er_o <= tx_er_i;
		end else if (tick) begin
			rxd_o   <= 4'h0;
			rx_dv_o <= 1'b0;
			rx_er_o <= 1'b0;
			case (state)
				PRX_ST_WAIT: begin
					if (sym == `PRX_SYM_BEACON && beacon_seen) begin
						rx_er_o <= 1'b1;
						rxd_o   <= `PRX_NIB_BEACON;
					end else if (sym == `PRX_SYM_SYNC && sync_seen) begin
						rx_er_o <= 1'b1;
						rxd_o   <= `PRX_NIB_COMMIT;
					end
				end
				PRX_ST_LOCK: begin
					rx_dv_o <= 1'b1;
					rxd_o   <= `PRX_NIB_PREAMBLE;
				end
				PRX_ST_DATA: begin
					if (sym != `PRX_SYM_ESD && sym != `PRX_SYM_IDLE) begin
						rx_dv_o <= 1'b1;
						rxd_o   <= clear_nibble;
						rx_er_o <= ~raw_valid;
					end
				end
				PRX_ST_END: begin
					rx_er_o <= (sym == `PRX_SYM_ESDJAB) || (sym == `PRX_SYM_ESDERR);
				end
				default: begin
					rx_er_o <= 1'b0;
				end
			endcase
		end
	end

	assign pma_tx_en_o = tx_en_i & ~loopback;
	assign pma_tx_er_o = tx_er_i & ~loopback;
	assign pma_txd_o   = txd_i;

	// carrier and collision, registered for clean mii levels
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			crs_o <= 1'b0;
			col_o <= 1'b0;
		end else begin
			crs_o <= loopback ? tx_en_i : crs_s;
			col_o <= tx_en_i & corrupt_s & ~loopback;
		end
	end

	// wishbone slave, one wait state, unmapped reads give zero
	assign wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign jab_clear = wb_req & wb_we_i & (wb_adr_i == `PRX_ADR_JABCNT) & wb_sel_i[0];
	assign jab_event = tick & ~loopback & (state == PRX_ST_END) & (sym == `PRX_SYM_ESDJAB);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= 32'h0000_0000;
			if (wb_req && !wb_we_i) begin
				if (wb_adr_i == `PRX_ADR_CTRL) begin
					wb_dat_o <= {31'h0000_0000, loopback};
				end else if (wb_adr_i == `PRX_ADR_STATUS) begin
					wb_dat_o <= {24'h00_0000, 1'b0, FALSE_CARRIER_OPTION, crs_s, corrupt_s,
						1'b0, state};
				end else if (wb_adr_i == `PRX_ADR_JABCNT) begin
					wb_dat_o <= {16'h0000, jab_count};
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			loopback <= 1'(`PRX_CTRL_RESET);
		end else if (wb_req && wb_we_i && wb_adr_i == `PRX_ADR_CTRL && wb_sel_i[0]) begin
			loopback <= wb_dat_i[`PRX_CTRL_LOOP_BIT];
		end
	end

	// an event with a clear in the same cycle leaves a count of one; counter saturates
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			jab_count <= '0;
		end else if (jab_event) begin
			jab_count <= jab_clear ? `PRX_JAB_WIDTH'(1) :
				(&jab_count ? jab_count : jab_count + `PRX_JAB_WIDTH'(1));
		end else if (jab_clear) begin
			jab_count <= '0;
		end
	end

	loop_return_a: assert property (@(posedge clk_i) disable iff (rst_i)
		loopback |=> (rxd_o == $past(txd_i)) && (rx_dv_o == $past(tx_en_i)))
		else $error("loopback data not returned");

	tx_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
		loopback |-> !pma_tx_en_o)
		else $error("transmit reached medium in loopback");

	col_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!tx_en_i |=> !col_o)
		else $error("col held without transmit enable");

	col_raise_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(tx_en_i && corrupt_s && !loopback) |=> col_o)
		else $error("col missing during collision");

	crs_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!loopback |=> (crs_o == $past(crs_s)))
		else $error("crs does not follow carrier");

	rx_tick_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(!tick && !loopback) |=> $stable(rxd_o) && $stable(rx_dv_o))
		else $error("receive output changed between ticks");

	lock_five_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(tick && !loopback && state == PRX_ST_LOCK) |=> rx_dv_o && (rxd_o == 4'h5))
		else $error("preamble nibble missing while locking");

	lock_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(tick && state == PRX_ST_LOCK && lock_cnt == 4'h8) |=> (state == PRX_ST_DATA))
		else $error("lock interval not nine symbols");

	bad_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(tick && !loopback && state == PRX_ST_DATA && !raw_valid
			&& sym != `PRX_SYM_ESD && sym != `PRX_SYM_IDLE) |=> rx_er_o && rx_dv_o)
		else $error("unmapped symbol without rx error");

	jab_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(jab_event && !jab_clear && !(&jab_count)) |=> (jab_count == $past(jab_count) + 16'h1))
		else $error("jabber event not counted");
endmodule : prx_rx_decode

// *** bench/prx_mac_model.sv ***
// mac side model: a burst of nibbles on the mii transmit path
// assumes the clk_i domain; txd keeps changing when not sending
`timescale 1ns/1ps
module prx_mac_model (
	input  wire logic       clk_i,
	input  wire logic       send_i,
	input  wire logic [3:0] len_i,
	output logic            tx_en_o,
	output logic            tx_er_o,
	output logic      [3:0] txd_o
);
	logic [3:0] left = 4'h0;
	logic [3:0] cnt  = 4'h0;
	// plain always: the start values above need no reset port
	always @(posedge clk_i) begin
		left <= send_i ? len_i : (left != 4'h0) ? left - 4'h1 : 4'h0;
	end
	always @(posedge clk_i) begin
		cnt <= cnt + 4'h1;
	end
	assign tx_en_o = (left != 4'h0);
	// error on odd nibbles so the error path is exercised too
	assign tx_er_o = tx_en_o & cnt[0];
	assign txd_o   = cnt;
endmodule : prx_mac_model

// *** bench/prx_rx_decode_test.sv ***
// bench for the receive decode block: wishbone, pma symbols, mii
// assumes a free clock and a symbol clock that stands still between frames
`timescale 1ns/1ps
`include "prx_regs.svh"
module prx_rx_decode_test;
	logic        clk, rst, cyc, stb, we, ack, rxclk, crs, cor, send;
	logic        ptx_en, ptx_er, tx_en, tx_er, dv, er, crso, colo;
	logic [7:0]  adr;
	logic [31:0] wdat, rdat, rd;
	logic [4:0]  symv;
	logic [3:0]  len, ptxd, txd, rxd, e;
	logic [5:0]  p;
	logic [16:0] s;
	int          fails, tests_run, cyc_n;
	logic [4:0]  enc [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
		5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
	prx_rx_decode #(.FALSE_CARRIER_OPTION(1'b1)) dut_u (.clk_i(clk), .rst_i(rst),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pma_rxclk_i(rxclk),
		.pma_sym_i(symv), .pma_crs_i(crs), .pma_corrupt_i(cor), .tx_en_i(ptx_en),
		.tx_er_i(ptx_er), .txd_i(ptxd), .pma_tx_en_o(tx_en), .pma_tx_er_o(tx_er),
		.pma_txd_o(txd), .rxd_o(rxd), .rx_dv_o(dv), .rx_er_o(er), .crs_o(crso), .col_o(colo));
	prx_mac_model mac_u (.clk_i(clk), .send_i(send), .len_i(len), .tx_en_o(ptx_en),
		.tx_er_o(ptx_er), .txd_o(ptxd));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	function automatic logic [3:0] dscr(input logic [3:0] n);
		logic [3:0] o;
		for (int i = 0; i < 4; i++) begin
			o[i] = n[i] ^ s[13] ^ s[16];
			s = {s[15:0], n[i]};
		end
		return o;
	endfunction : dscr
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		tests_run++;
		if (g !== x) begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, x, g);
		end
	endtask : chk
	task automatic rx(input logic [5:0] x);
		chk("rx_dv_er_rxd", {26'h0, x}, {26'h0, dv, er, rxd});
	endtask : rx
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		// read data taken at the edge that samples ack high
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20) chk("wb_ack", 1, 0);
	endtask : wb
	task automatic sym(input logic [4:0] v);
		@(posedge clk);
		rxclk <= 1'b0;
		symv <= v;
		repeat (5) @(posedge clk);
		rxclk <= 1'b1;
		repeat (5) @(posedge clk);
		#1;
	endtask : sym
	task automatic t_regs();
		wb(1'b0, `PRX_ADR_CTRL, 0);
		chk("ctrl", `PRX_CTRL_RESET, rd);
		wb(1'b0, `PRX_ADR_STATUS, 0);
		chk("status", 32'h40, rd);
		wb(1'b1, 8'h0c, 32'hffff_ffff);
		wb(1'b0, 8'h0c, 0);
		chk("unmapped", 0, rd);
		wb(1'b0, `PRX_ADR_JABCNT, 0);
		chk("jabcnt", 0, rd);
	endtask : t_regs
	task automatic t_frame();
		sym(`PRX_SYM_SYNC);
		sym(`PRX_SYM_SYNC);
		rx({2'b01, `PRX_NIB_COMMIT});
		sym(`PRX_SYM_SSD);
		sym(`PRX_SYM_SSD);
		s = `PRX_SCR_RESET;
		for (int i = 0; i < 9; i++) begin
			sym(enc[i]);
			e = dscr(i[3:0]);
			rx({2'b10, `PRX_NIB_PREAMBLE});
		end
		for (int i = 9; i < 16; i++) begin
			e = dscr(i[3:0]);
			sym(enc[i]);
			rx({2'b10, e});
		end
		sym(5'h00);
		e = dscr(4'h0);
		chk("rx_er", 1, er);
		e = dscr(4'h6);
		sym(enc[6]);
		rx({2'b10, e});
		sym(`PRX_SYM_ESD);
		rx(6'h00);
		sym(`PRX_SYM_ESDJAB);
		chk("rx_er", 1, er);
		sym(`PRX_SYM_IDLE);
		wb(1'b0, `PRX_ADR_JABCNT, 0);
		chk("jabcnt", 1, rd);
		wb(1'b1, `PRX_ADR_JABCNT, 0);
		wb(1'b0, `PRX_ADR_JABCNT, 0);
		chk("jabcnt", 0, rd);
	endtask : t_frame
	task automatic t_beacon();
		sym(`PRX_SYM_BEACON);
		sym(`PRX_SYM_BEACON);
		rx({2'b01, `PRX_NIB_BEACON});
		sym(`PRX_SYM_IDLE);
	endtask : t_beacon
	task automatic t_loop();
		wb(1'b1, `PRX_ADR_CTRL, 1);
		send <= 1'b1;
		len <= 4'h6;
		@(posedge clk);
		send <= 1'b0;
		repeat (8) begin
			@(posedge clk);
			p = {ptx_en, ptx_er, ptxd};
			#1;
			rx(p);
			chk("pma_tx_en", 0, tx_en);
			chk("pma_tx_er", 0, tx_er);
			chk("crs", p[5], crso);
		end
		wb(1'b1, `PRX_ADR_CTRL, 0);
	endtask : t_loop
	task automatic t_col();
		cor <= 1'b1;
		crs <= 1'b1;
		send <= 1'b1;
		len <= 4'hf;
		@(posedge clk);
		send <= 1'b0;
		repeat (6) @(posedge clk);
		#1;
		chk("crs", 1, crso);
		chk("col", 1, colo);
		chk("pma_tx_en", 1, tx_en);
		chk("pma_tx_er", ptx_er, tx_er);
		chk("pma_txd", ptxd, txd);
		repeat (14) @(posedge clk);
		#1;
		chk("col", 0, colo);
		@(posedge clk);
		cor <= 1'b0;
		crs <= 1'b0;
		repeat (6) @(posedge clk);
		#1;
		chk("crs", 0, crso);
	endtask : t_col
	task automatic results();
		$display("fails=%0d tests_run=%0d", fails, tests_run);
		if (fails == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results
	initial begin
		cyc_n = 0;
		forever begin
			@(posedge clk);
			cyc_n++;
			if (cyc_n > 20000) begin
				fails++;
				results();
			end
		end
	end
	initial begin
		{rst, cyc, stb, we, rxclk, crs, cor, send} = 8'h80;
		adr = 8'h00;
		wdat = 32'h0;
		symv = `PRX_SYM_IDLE;
		len = 4'h0;
		fails = 0;
		tests_run = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_frame();
		t_beacon();
		t_loop();
		t_col();
		results();
	end
endmodule : prx_rx_decode_test
